// ===== common/pvt_params.svh
`ifndef PVT_PARAMS_SVH
`define PVT_PARAMS_SVH
// ==========================================
// Register map
`define PVT_ADDR_W 4
`define PVT_OFS_CTRL 4'h0
`define PVT_OFS_STAT 4'h4
`define PVT_CFG_W 10
`define PVT_CFG_MASK 10'h377
`define PVT_CTL_TAP 1:0
`define PVT_CTL_RFORM 2
`define PVT_CTL_ENC 6:4
`define PVT_CTL_SER 9:8
// ==========================================
// Output frame
`define PVT_FRAME_W 10'h280
`define PVT_FRAME_H 10'h200
`define PVT_CNT_W 10
`define PVT_CNT_MAX 10'h3FF
`endif

// ===== common/pvt_pkg.sv
package pvt_pkg;
    // ==========================================
    // Tap points
    typedef enum logic [1:0] {
        TAP_LINEAR = 2'b00,
        TAP_RADIO = 2'b01,
        TAP_AGC = 2'b10,
        TAP_COLOR = 2'b11
    } pvt_tap_t;
    // ==========================================
    // Colour encodings
    typedef enum logic [2:0] {
        ENC_YCBCR = 3'b000,
        ENC_YCRCB = 3'b001,
        ENC_CRCBY = 3'b010,
        ENC_CBCRY = 3'b011,
        ENC_RGB = 3'b100,
        ENC_BGR = 3'b101,
        ENC_YCBCR_MUX = 3'b110,
        ENC_YCRCB_MUX = 3'b111
    } pvt_enc_t;
endpackage : pvt_pkg

// ===== src/pvt_sync.sv
module pvt_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // ==========================================
    // Three stages, change taken when two agree
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_q;
    wire agree = (s2_q == s3_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                q_q <= s3_q;
            end
        end
    end

    assign q = q_q;
endmodule : pvt_sync

// ===== src/pvt_color.sv
module pvt_color
    import pvt_pkg::*;
(
    input wire pvt_enc_t enc,
    input wire logic [1:0] slot,
    input wire logic [7:0] y,
    input wire logic [7:0] cb,
    input wire logic [7:0] cr,
    input wire logic [7:0] r,
    input wire logic [7:0] g,
    input wire logic [7:0] b,
    output logic [23:0] word
);
    // ==========================================
    // Chroma sequencing
    wire even = ~slot[0];
    wire [7:0] chr_b1 = even ? cb : cr;
    wire [7:0] chr_r1 = even ? cr : cb;
    wire [7:0] mux_b1 = slot[0] ? (slot[1] ? cr : cb) : y; // R13
    wire [7:0] mux_r1 = slot[0] ? (slot[1] ? cb : cr) : y; // R14
    // ==========================================
    // Bit interleaved 8:8:8
    wire [23:0] rgb_w;
    wire [23:0] bgr_w;
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_il
            assign rgb_w[3*k] = g[7-k]; // R11
            assign rgb_w[3*k+1] = r[7-k]; // R11
            assign rgb_w[3*k+2] = b[7-k]; // R11
            assign bgr_w[3*k] = g[7-k]; // R12
            assign bgr_w[3*k+1] = b[7-k]; // R12
            assign bgr_w[3*k+2] = r[7-k]; // R12
        end
    endgenerate
    // ==========================================
    // Lane placement, idle lanes zero
    wire [23:0] w_ycbcr = {8'h00, chr_b1, y}; // R7
    wire [23:0] w_ycrcb = {8'h00, chr_r1, y}; // R8
    wire [23:0] w_crcby = {8'h00, y, chr_r1}; // R9
    wire [23:0] w_cbcry = {8'h00, y, chr_b1}; // R10
    wire [23:0] w_mux_b = {16'h0000, mux_b1}; // R13 R17
    wire [23:0] w_mux_r = {16'h0000, mux_r1}; // R14 R17

    assign word = (enc == ENC_YCBCR) ? w_ycbcr :
                  (enc == ENC_YCRCB) ? w_ycrcb :
                  (enc == ENC_CRCBY) ? w_crcby :
                  (enc == ENC_CBCRY) ? w_cbcry :
                  (enc == ENC_RGB) ? rgb_w :
                  (enc == ENC_BGR) ? bgr_w :
                  (enc == ENC_YCBCR_MUX) ? w_mux_b : w_mux_r;
endmodule : pvt_color

// ===== src/pvt_top.sv
`include "pvt_params.svh"

//
// Behaviour
// R1: Linear tap sends 16-bit irradiance on lines 0-15, ignores AGC/zoom/colour.
// R2: Radiometric units add a 16-bit radiometric tap, default there, two forms.
// R3: AGC tap sends 8-bit enhanced pixels on lines 0-7, ignores zoom/colour.
// R4: Colour tap always delivers 640x512 frames; the code only crops larger input, smaller frames are not padded.
// R5: Colour tap pixels are palette mapped then formatted by encoding.
// R6: Encoding only matters while the colour tap is selected.
// R7: YCbCr: luma on 0-7, Cb on even clocks, Cr on odd, lines 8-15.
// R8: YCrCb: like YCbCr but Cr on even clocks, Cb on odd.
// R9: CrCbY: YCrCb sequence with luma and chroma bytes swapped.
// R10: CbCrY: YCbCr sequence with luma and chroma bytes swapped.
// R11: RGB: 24 bits per clock, green n, red n+1, blue n+2.
// R12: BGR: 24 bits per clock, green n, blue n+1, red n+2.
// R13: Muxed YCbCr: lines 0-7, Y Cb Y Cr groups, two clocks per pixel.
// R14: Muxed YCrCb: as muxed YCbCr with Cr second and Cb fourth.
// R15: Serial output taps the pipeline independently of the parallel output.
// R16: Host should rely only on the two plain 4:2:2 luma-chroma encodings.
// R17: Data lines unused by the current format are driven to zero.
// R18: Tap and encoding changes apply only at a frame boundary.
module pvt_top
    import pvt_pkg::*;
#(
    parameter bit RAD_CAPABLE = 1'b1
) (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic [`PVT_ADDR_W-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic PIX_CLK,
    input wire logic VID_SOF,
    input wire logic VID_SOL,
    input wire logic VID_VALID,
    output logic VID_READY,
    input wire logic [15:0] LIN_DATA,
    input wire logic [15:0] RAD_TS_DATA,
    input wire logic [15:0] RAD_TL_DATA,
    input wire logic [7:0] AGC_DATA,
    input wire logic [7:0] COL_Y,
    input wire logic [7:0] COL_CB,
    input wire logic [7:0] COL_CR,
    input wire logic [7:0] COL_R,
    input wire logic [7:0] COL_G,
    input wire logic [7:0] COL_B,
    output logic [23:0] OUT_DATA,
    output logic OUT_VALID,
    output logic OUT_SOF,
    output logic OUT_SOL,
    output logic [15:0] SER_DATA,
    output logic SER_VALID
);
    localparam int CW = `PVT_CFG_W;
    localparam pvt_tap_t TAP_RST = RAD_CAPABLE ? TAP_RADIO : TAP_LINEAR; // R2
    localparam logic [CW-1:0] CFG_RST =
        {TAP_LINEAR, 1'b0, ENC_YCBCR, 1'b0, 1'b0, TAP_RST};

    function automatic logic is_mux(input pvt_enc_t e);
        is_mux = (e == ENC_YCBCR_MUX) || (e == ENC_YCRCB_MUX);
    endfunction : is_mux

    // ==========================================
    // Register port, reference clock
    logic [CW-1:0] ctrl_q;
    logic [CW-1:0] xfer_q;
    logic req_q;
    logic ack_r;
    logic [31:0] rdata_q;
    wire sel_ctrl = (REG_ADDR == `PVT_OFS_CTRL);
    wire sel_stat = (REG_ADDR == `PVT_OFS_STAT);
    wire wr_ctrl = REG_WR && sel_ctrl;
    wire idle = (req_q == ack_r);
    wire launch = idle && (ctrl_q != xfer_q);
    wire pend = !idle || (ctrl_q != xfer_q);
    wire [31:0] rd_ctrl = {22'h00_0000, ctrl_q};
    wire [31:0] rd_stat = {6'h00, xfer_q, 15'h0000, pend};
    wire [31:0] rdata_d = !REG_RD ? 32'h0000_0000 :
                          sel_ctrl ? rd_ctrl :
                          sel_stat ? rd_stat : 32'h0000_0000;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_q <= CFG_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= REG_WDATA[CW-1:0] & `PVT_CFG_MASK;
            end
            rdata_q <= rdata_d;
        end
    end

    // Word handed over by toggle handshake
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            xfer_q <= CFG_RST;
            req_q <= 1'b0;
        end else if (launch) begin
            xfer_q <= ctrl_q;
            req_q <= ~req_q;
        end
    end

    assign REG_RDATA = rdata_q;

    // ==========================================
    // Crossings
    logic req_p;
    logic ack_q;

    pvt_sync #(.W(1)) u_req_sync (
        .clk(PIX_CLK),
        .rst_n(RESET_N),
        .d(req_q),
        .q(req_p)
    );

    pvt_sync #(.W(1)) u_ack_sync (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .d(ack_q),
        .q(ack_r)
    );

    // ==========================================
    // Active format, swapped only at frame start
    logic [CW-1:0] act_q;
    wire apply = VID_SOF && (req_p != ack_q);

    always_ff @(posedge PIX_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            act_q <= CFG_RST;
            ack_q <= 1'b0;
        end else if (apply) begin
            act_q <= xfer_q; // R18
            ack_q <= req_p; // R18
        end
    end

    wire [CW-1:0] cfg_cur = apply ? xfer_q : act_q; // R18
    wire pvt_tap_t tap_a = pvt_tap_t'(act_q[`PVT_CTL_TAP]);
    wire pvt_tap_t ser_a = pvt_tap_t'(cfg_cur[`PVT_CTL_SER]);
    wire pvt_enc_t enc_a = pvt_enc_t'(act_q[`PVT_CTL_ENC]);
    wire pvt_enc_t enc_n = pvt_enc_t'(cfg_cur[`PVT_CTL_ENC]);
    wire rform_a = act_q[`PVT_CTL_RFORM];
    wire rform_n = cfg_cur[`PVT_CTL_RFORM];
    wire no_rad = !RAD_CAPABLE;
    wire pvt_tap_t tap_e = (tap_a == TAP_RADIO && no_rad) ? TAP_LINEAR : tap_a;
    wire color = (tap_e == TAP_COLOR);
    wire color_n = (cfg_cur[`PVT_CTL_TAP] == TAP_COLOR);
    wire mux_a = color_n && is_mux(enc_n); // R6

    // ==========================================
    // Line and frame position
    logic [`PVT_CNT_W-1:0] col_q;
    logic [`PVT_CNT_W-1:0] row_q;
    logic [1:0] ph_q;
    logic rdy_q;
    wire [`PVT_CNT_W-1:0] col_cur = VID_SOL ? '0 : col_q;
    wire [`PVT_CNT_W-1:0] row_inc = (row_q == `PVT_CNT_MAX) ? row_q :
                                    row_q + 1'b1;
    wire [`PVT_CNT_W-1:0] row_cur = VID_SOF ? '0 :
                                    VID_SOL ? row_inc : row_q;
    wire [1:0] ph_cur = VID_SOL ? 2'h0 : ph_q;
    wire in_win = (col_cur < `PVT_FRAME_W) && (row_cur < `PVT_FRAME_H); // R4
    wire take = VID_VALID && rdy_q;
    wire emit_take = take && (!color_n || in_win); // R4
    wire emit_odd = mux_a && ph_cur[0]; // R13
    wire emit = emit_take || emit_odd;
    wire [1:0] ph_nx = emit ? ph_cur + 2'h1 : ph_cur;
    wire rdy_d = !mux_a || !ph_nx[0]; // R13 R14
    wire col_sat = (col_cur == `PVT_CNT_MAX);
    wire [`PVT_CNT_W-1:0] col_nx = (take && !col_sat) ? col_cur + 1'b1 :
                                   col_cur;

    always_ff @(posedge PIX_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            col_q <= '0;
            row_q <= '0;
            ph_q <= 2'h0;
            rdy_q <= 1'b1;
        end else begin
            col_q <= col_nx;
            row_q <= row_cur;
            ph_q <= ph_nx;
            rdy_q <= rdy_d;
        end
    end

    // ==========================================
    // Pixel capture stage
    logic [15:0] lin_h_q;
    logic [15:0] ts_h_q;
    logic [15:0] tl_h_q;
    logic [7:0] agc_h_q;
    logic [7:0] y_h_q;
    logic [7:0] cb_h_q;
    logic [7:0] cr_h_q;
    logic [7:0] r_h_q;
    logic [7:0] g_h_q;
    logic [7:0] b_h_q;
    logic [1:0] slot_q;
    logic vld1_q;
    logic sof1_q;
    logic sol1_q;

    always_ff @(posedge PIX_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lin_h_q <= 16'h0000;
            ts_h_q <= 16'h0000;
            tl_h_q <= 16'h0000;
            agc_h_q <= 8'h00;
        end else if (take) begin
            lin_h_q <= LIN_DATA;
            ts_h_q <= RAD_TS_DATA;
            tl_h_q <= RAD_TL_DATA;
            agc_h_q <= AGC_DATA;
        end
    end

    always_ff @(posedge PIX_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            y_h_q <= 8'h00;
            cb_h_q <= 8'h00;
            cr_h_q <= 8'h00;
            r_h_q <= 8'h00;
            g_h_q <= 8'h00;
            b_h_q <= 8'h00;
        end else if (take) begin
            y_h_q <= COL_Y; // R5
            cb_h_q <= COL_CB;
            cr_h_q <= COL_CR;
            r_h_q <= COL_R;
            g_h_q <= COL_G;
            b_h_q <= COL_B;
        end
    end

    always_ff @(posedge PIX_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            slot_q <= 2'h0;
            vld1_q <= 1'b0;
            sof1_q <= 1'b0;
            sol1_q <= 1'b0;
        end else begin
            slot_q <= ph_cur;
            vld1_q <= emit;
            sof1_q <= VID_SOF;
            sol1_q <= VID_SOL;
        end
    end

    // ==========================================
    // Output formatting
    logic [23:0] col_w;
    pvt_color u_color (
        .enc(enc_a),
        .slot(slot_q),
        .y(y_h_q),
        .cb(cb_h_q),
        .cr(cr_h_q),
        .r(r_h_q),
        .g(g_h_q),
        .b(b_h_q),
        .word(col_w)
    );

    wire [15:0] rad_w = rform_a ? tl_h_q : ts_h_q; // R2
    wire [23:0] w_lin = {8'h00, lin_h_q}; // R1 R17
    wire [23:0] w_rad = {8'h00, rad_w}; // R2 R17
    wire [23:0] w_agc = {16'h0000, agc_h_q}; // R3 R17
    wire [23:0] fmt_w = (tap_e == TAP_LINEAR) ? w_lin :
                        (tap_e == TAP_RADIO) ? w_rad :
                        (tap_e == TAP_AGC) ? w_agc : col_w; // R5 R6
    wire [23:0] out_d = vld1_q ? fmt_w : 24'h00_0000; // R17

    logic [23:0] out_q;
    logic out_vld_q;
    logic out_sof_q;
    logic out_sol_q;
    always_ff @(posedge PIX_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_q <= 24'h00_0000;
            out_vld_q <= 1'b0;
            out_sof_q <= 1'b0;
            out_sol_q <= 1'b0;
        end else begin
            out_q <= out_d;
            out_vld_q <= vld1_q;
            out_sof_q <= sof1_q;
            out_sol_q <= sol1_q;
        end
    end

    // ==========================================
    // Serial tap, independent selection
    wire [15:0] ser_d = (ser_a == TAP_LINEAR) ? LIN_DATA :
                        (ser_a == TAP_RADIO) ?
                            (rform_n ? RAD_TL_DATA : RAD_TS_DATA) :
                        (ser_a == TAP_AGC) ? {8'h00, AGC_DATA} :
                        {8'h00, COL_Y}; // R15
    logic [15:0] ser_q;
    logic ser_vld_q;
    always_ff @(posedge PIX_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ser_q <= 16'h0000;
            ser_vld_q <= 1'b0;
        end else begin
            ser_q <= VID_VALID ? ser_d : 16'h0000; // R15
            ser_vld_q <= VID_VALID;
        end
    end

    assign VID_READY = rdy_q;
    assign OUT_DATA = out_q;
    assign OUT_VALID = out_vld_q;
    assign OUT_SOF = out_sof_q;
    assign OUT_SOL = out_sol_q;
    assign SER_DATA = ser_q;
    assign SER_VALID = ser_vld_q;

    // ==========================================
    // Checks
    a_lin_pass: // R1
    assert property (@(posedge PIX_CLK) disable iff (!RESET_N)
        vld1_q && tap_e == TAP_LINEAR |=>
        OUT_DATA == {8'h00, $past(lin_h_q)})
    else $error("linear tap word wrong");
    a_rad_form: // R2
    assert property (@(posedge PIX_CLK) disable iff (!RESET_N)
        vld1_q && tap_e == TAP_RADIO && rform_a |=>
        OUT_DATA[15:0] == $past(tl_h_q))
    else $error("radiometric form wrong");
    a_agc_byte: // R3
    assert property (@(posedge PIX_CLK) disable iff (!RESET_N)
        vld1_q && tap_e == TAP_AGC |=>
        OUT_DATA == {16'h0000, $past(agc_h_q)})
    else $error("agc tap word wrong");
    a_win_drop: // R4
    assert property (@(posedge PIX_CLK) disable iff (!RESET_N)
        take && color_n && !in_win && !emit_odd |=> !vld1_q)
    else $error("pixel outside 640x512 emitted");
    a_ycbcr_even: // R7
    assert property (@(posedge PIX_CLK) disable iff (!RESET_N)
        vld1_q && color && enc_a == ENC_YCBCR && !slot_q[0] |=>
        OUT_DATA == {8'h00, $past(cb_h_q), $past(y_h_q)})
    else $error("ycbcr even word wrong");
    a_mux_slot: // R13
    assert property (@(posedge PIX_CLK) disable iff (!RESET_N)
        vld1_q && color && enc_a == ENC_YCBCR_MUX && slot_q == 2'h1 |=>
        OUT_DATA == {16'h0000, $past(cb_h_q)})
    else $error("muxed slot one not blue chroma");
    a_mux_stall: // R13
    assert property (@(posedge PIX_CLK) disable iff (!RESET_N)
        mux_a && emit_take && !ph_cur[0] |=>
        !VID_READY ##1 OUT_VALID)
    else $error("muxed pixel not given two clocks");
    a_rad_upper: // R17
    assert property (@(posedge PIX_CLK) disable iff (!RESET_N)
        vld1_q && tap_e == TAP_RADIO |=> OUT_DATA[23:16] == 8'h00)
    else $error("unused lines not zero");
    a_frame_apply: // R18
    assert property (@(posedge PIX_CLK) disable iff (!RESET_N)
        !VID_SOF |=> $stable(act_q))
    else $error("format changed inside a frame");
endmodule : pvt_top

// ===== testbench/pvt_host_model.sv
// ==========================================
// Host capture of parallel and serial video
module pvt_host_model (
    input wire logic pix_clk,
    input wire logic rst_n,
    input wire logic [23:0] out_data,
    input wire logic out_valid,
    input wire logic out_sof,
    input wire logic out_sol,
    input wire logic [15:0] ser_data,
    input wire logic ser_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] vid_q[$];
    logic [15:0] ser_q[$];
    int n_sof = 0;
    int n_sol = 0;
    int n_idle_bad = 0;

    // ==========================================
    // Word capture, idle lines watched
    always @(posedge pix_clk) begin
        if (rst_n) begin
            if (out_valid === 1'b1) begin
                vid_q.push_back(out_data);
            end else if (out_data !== 24'h0) begin
                n_idle_bad++;
            end
            if (ser_valid === 1'b1) begin
                ser_q.push_back(ser_data);
            end
            if (out_sof === 1'b1) begin
                n_sof++;
            end
            if (out_sol === 1'b1) begin
                n_sol++;
            end
        end
    end
endmodule : pvt_host_model

// ===== testbench/tb_pvt_top.sv
`include "pvt_params.svh"

module tb_pvt_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic REF_CLK = 1'b0;
    logic PIX_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [3:0] REG_ADDR = 4'h0;
    logic [31:0] REG_WDATA = 32'h0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [31:0] REG_RDATA;
    logic VID_SOF = 1'b0;
    logic VID_SOL = 1'b0;
    logic VID_VALID = 1'b0;
    logic VID_READY;
    logic [15:0] LIN_DATA = 16'h0;
    logic [15:0] RAD_TS_DATA = 16'h0;
    logic [15:0] RAD_TL_DATA = 16'h0;
    logic [7:0] AGC_DATA = 8'h0;
    logic [7:0] COL_Y = 8'h0;
    logic [7:0] COL_CB = 8'h0;
    logic [7:0] COL_CR = 8'h0;
    logic [7:0] COL_R = 8'h0;
    logic [7:0] COL_G = 8'h0;
    logic [7:0] COL_B = 8'h0;
    logic [23:0] OUT_DATA;
    logic OUT_VALID;
    logic OUT_SOF;
    logic OUT_SOL;
    logic [15:0] SER_DATA;
    logic SER_VALID;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [23:0] exp_v[$];
    logic [15:0] exp_s[$];
    logic [9:0] cfgs[10] = '{10'h240, 10'h005, 10'h052, 10'h003, 10'h013,
        10'h023, 10'h033, 10'h043, 10'h053, 10'h063};

    initial begin
        forever #12.5 REF_CLK = ~REF_CLK;
    end
    initial begin
        #13;
        forever #40 PIX_CLK = ~PIX_CLK;
    end

    pvt_top dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .PIX_CLK(PIX_CLK), .VID_SOF(VID_SOF),
        .VID_SOL(VID_SOL), .VID_VALID(VID_VALID), .VID_READY(VID_READY),
        .LIN_DATA(LIN_DATA), .RAD_TS_DATA(RAD_TS_DATA),
        .RAD_TL_DATA(RAD_TL_DATA), .AGC_DATA(AGC_DATA), .COL_Y(COL_Y),
        .COL_CB(COL_CB), .COL_CR(COL_CR), .COL_R(COL_R), .COL_G(COL_G),
        .COL_B(COL_B), .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID),
        .OUT_SOF(OUT_SOF), .OUT_SOL(OUT_SOL), .SER_DATA(SER_DATA),
        .SER_VALID(SER_VALID));

    pvt_host_model cap (.pix_clk(PIX_CLK), .rst_n(RESET_N),
        .out_data(OUT_DATA), .out_valid(OUT_VALID), .out_sof(OUT_SOF),
        .out_sol(OUT_SOL), .ser_data(SER_DATA), .ser_valid(SER_VALID));

    // ==========================================
    // Checking and register access
    task close_out;
        $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge REF_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        @(negedge REF_CLK);
        d = REG_RDATA;
    endtask : rd

    // ==========================================
    // Expected output word per pixel and slot
    function automatic logic [23:0] expw(input logic [9:0] c,
        input logic [7:0] v, input logic odd, input logic s);
        logic [7:0] ch, r, g, b;
        logic [23:0] w;
        logic cbf;
        cbf = (c[6:4] == 3'h0) || (c[6:4] == 3'h3) || (c[6:4] == 3'h6);
        ch = (cbf ^ odd) ? (v ^ 8'h5A) : (v ^ 8'hC3);
        r = v + 8'h21;
        g = v + 8'h47;
        b = v ^ 8'h96;
        w = 24'h0;
        case (c[1:0])
            2'h0: w = {8'h0, 8'hA5, v};
            2'h1: w = {8'h0, (c[2] ? 8'h69 : 8'h3C), v};
            2'h2: w = {16'h0, ~v};
            default: begin
                case (c[6:5])
                    2'h0: w = {8'h0, ch, v};
                    2'h1: w = {8'h0, v, ch};
                    2'h2: begin
                        for (int k = 0; k < 8; k++) begin
                            w[3 * k] = g[7 - k];
                            w[3 * k + 1] = c[4] ? b[7 - k] : r[7 - k];
                            w[3 * k + 2] = c[4] ? r[7 - k] : b[7 - k];
                        end
                    end
                    default: w = s ? {16'h0, ch} : {16'h0, v};
                endcase
            end
        endcase
        return w;
    endfunction : expw

    task pix(input logic [7:0] v, input logic sof, input logic sol);
        logic ok;
        VID_VALID <= 1'b1;
        VID_SOF <= sof;
        VID_SOL <= sol;
        LIN_DATA <= {8'hA5, v};
        RAD_TS_DATA <= {8'h3C, v};
        RAD_TL_DATA <= {8'h69, v};
        AGC_DATA <= ~v;
        COL_Y <= v;
        COL_CB <= v ^ 8'h5A;
        COL_CR <= v ^ 8'hC3;
        COL_R <= v + 8'h21;
        COL_G <= v + 8'h47;
        COL_B <= v ^ 8'h96;
        ok = 1'b0;
        while (!ok) begin
            @(negedge PIX_CLK);
            ok = (VID_READY === 1'b1);
            @(posedge PIX_CLK);
        end
    endtask : pix

    // ==========================================
    // One frame: optional config write, pixels, comparison
    task run_frame(input logic [9:0] c, input int w, input int h,
        input bit wr_first, input bit chg, input logic [9:0] nxt);
        logic [31:0] d;
        logic [7:0] v;
        logic mux;
        logic sok;
        mux = (c[1:0] == 2'h3) && (c[6:5] == 2'h3);
        sok = (c[8] == 1'b0) && !mux;
        if (wr_first) wr(`PVT_OFS_CTRL, {22'h0, c});
        repeat (12) @(posedge PIX_CLK);
        cap.vid_q.delete();
        cap.ser_q.delete();
        cap.n_sof = 0;
        cap.n_sol = 0;
        exp_v.delete();
        exp_s.delete();
        for (int y = 0; y < h; y++) begin
            for (int x = 0; x < w; x++) begin
                v = 8'(y * 16 + x);
                if (c[1:0] != 2'h3 || x < `PVT_FRAME_W) begin
                    exp_v.push_back(expw(c, v, x[0], 1'b0));
                    if (mux) exp_v.push_back(expw(c, v, x[0], 1'b1));
                end
                if (c[9:8] == 2'h0) exp_s.push_back({8'hA5, v});
                if (c[9:8] == 2'h2) exp_s.push_back({8'h0, ~v});
                pix(v, y == 0 && x == 0, x == 0);
            end
            VID_VALID <= 1'b0;
            VID_SOF <= 1'b0;
            VID_SOL <= 1'b0;
            if (chg && y == 0) wr(`PVT_OFS_CTRL, {22'h0, nxt});
            repeat (12) @(posedge PIX_CLK);
        end
        chk(32'(cap.vid_q.size()), 32'(exp_v.size()));
        chk(32'(cap.n_sof), 32'h0000_0001);
        chk(32'(cap.n_sol), 32'(h));
        foreach (exp_v[i]) begin
            if (i < cap.vid_q.size()) chk(cap.vid_q[i], exp_v[i]);
        end
        if (sok) chk(32'(cap.ser_q.size()), 32'(exp_s.size()));
        foreach (exp_s[i]) begin
            if (sok && i < cap.ser_q.size()) chk(cap.ser_q[i], exp_s[i]);
        end
        rd(`PVT_OFS_STAT, d);
        if (chg) begin
            chk(d[0], 1'b1);
        end else begin
            chk({d[25:16], d[0]}, {c, 1'b0});
        end
    endtask : run_frame

    // ==========================================
    // Main sequence and hang guard
    initial begin
        logic [31:0] d;
        repeat (10) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        run_frame(10'h001, 4, 2, 1'b0, 1'b0, 10'h0);
        foreach (cfgs[i]) begin
            run_frame(cfgs[i], 4, 2, 1'b1, 1'b0, 10'h0);
        end
        run_frame(10'h073, 5, 2, 1'b1, 1'b1, 10'h002);
        run_frame(10'h002, 3, 2, 1'b1, 1'b0, 10'h0);
        run_frame(10'h013, 641, 1, 1'b1, 1'b0, 10'h0);
        wr(`PVT_OFS_CTRL, 32'hFFFF_FFFF);
        rd(`PVT_OFS_CTRL, d);
        chk(d, 32'h0000_0377);
        wr(4'h8, 32'h1234_5678);
        rd(4'h8, d);
        chk(d, 32'h0);
        chk(32'(cap.n_idle_bad), 32'h0);
        close_out;
    end

    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out;
        end
    end
endmodule : tb_pvt_top
